// ---- rtm_chk_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtm_chk
  import rtm_pkg::*;
#(
  parameter int CH = NUM_CH
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic global_mode_strap_enable,
  input wire logic global_mode_strap_value,
  input wire logic rx_global_hiz_pin,
  input wire logic rx_differential,
  input wire logic [CH-1:0] rx_pulse_valid,
  input wire logic [CH-1:0] e1_mode,
  input wire logic [CH*2-1:0] term_kind,
  input wire logic [CH*2-1:0] internal_term_resistor,
  input wire logic [CH-1:0] external_term_resistor,
  input wire logic [CH*2-1:0] monitor_gain_sel,
  input wire logic [CH-1:0] rx_mark
);
  // =========
  // Decodes are combinational, so each is checked in the cycle it applies.
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  mode_global_a: assert property (
    global_mode_strap_enable |-> e1_mode == {CH{global_mode_strap_value}})
    else $error("strap mode");
  hiz_all_ext_a: assert property (
    !rx_global_hiz_pin |-> term_kind == '0 && external_term_resistor == '1)
    else $error("hiz kind");
  kind_legal_a: assert property (
    term_kind[1:0] != 2'h3) else $error("kind code");
  ext_no_res_a: assert property (
    term_kind[1:0] == RTM_TERM_EXT |-> internal_term_resistor[1:0] == 2'h0)
    else $error("ext res");
  part_uses_rr_a: assert property (
    external_term_resistor[0] == (term_kind[1:0] != RTM_TERM_FULL))
    else $error("rr use");
  gain_diff_a: assert property (
    !rx_differential |-> monitor_gain_sel == '0) else $error("gain");
  mark_hold_a: assert property (
    !rx_pulse_valid[0] |=> $stable(rx_mark[0])) else $error("mark");
  hiz_now_a: assert property (
    $fell(rx_global_hiz_pin) |-> term_kind == '0) else $error("hiz late");
endmodule
bind rtm_rx_term_ctrl rtm_chk #(.CH(CH)) chk_i (.*);
`default_nettype wire

// ---- rtm_pkg.sv ----
package rtm_pkg;

  // ==========================================================================
  // Geometry
  localparam int NUM_CH = 16;
  localparam int AXI_AW = 8;
  localparam int AMP_W = 8;

  // ==========================================================================
  // Register map, one aligned word per register
  localparam logic [7:0] CHAN_SEL_OFF = 8'h00;
  localparam logic [7:0] CHAN_CFG_OFF = 8'h04;
  localparam logic [7:0] RX_CFG0_OFF = 8'h08;
  localparam logic [7:0] RX_CFG2_OFF = 8'h0c;
  localparam logic [7:0] STATUS_OFF = 8'h10;
  localparam logic [7:0] PEAK_OFF = 8'h14;

  // ==========================================================================
  // Field positions
  localparam int E1_BIT = 0;
  localparam int TERM_EXT_BIT = 2;
  localparam int TERM_RES_LSB = 0;
  localparam int PART_INT_BIT = 4;
  localparam int GAIN_LSB = 0;
  localparam int STAT_E1_BIT = 0;
  localparam int STAT_KIND_LSB = 1;
  localparam int STAT_RES_LSB = 3;
  localparam int STAT_GAIN_LSB = 5;
  localparam int STAT_MARK_BIT = 7;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RX_CFG0_RST = 8'h04;
  localparam logic [7:0] RX_CFG2_RST = 8'h00;
  localparam logic [7:0] CHAN_CFG_RST = 8'h01;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RTM_TERM_EXT = 2'b00,
    RTM_TERM_PART = 2'b01,
    RTM_TERM_FULL = 2'b10
  } rtm_term_e;

  typedef enum logic [1:0] {
    RTM_GAIN_0DB = 2'b00,
    RTM_GAIN_20DB = 2'b01,
    RTM_GAIN_26DB = 2'b10,
    RTM_GAIN_32DB = 2'b11
  } rtm_gain_e;

endpackage

// ---- rtm_rx_term_ctrl.sv ----
// Functional notes
// - Strap enable open: global mode; low: per-channel bit.
// - Hiz pin low forces external matching everywhere.
// - Hiz pin high: per-channel termination choice.
// - Termination bit 2 zero enables internal matching.
// - Termination bit 2 one: external, other bits ignored.
// - Partial select picks partial or full internal.
// - Bits 1..0 set internal resistor value.
// - Two-bit gain: 0, 20, 26, 32 dB.
// - Monitor gain only on differential interface.
// - Slice each pulse at half detected peak.
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module rtm_rx_term_ctrl
  import rtm_pkg::*;
#(
  parameter int CH = NUM_CH
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic global_mode_strap_enable,
  input wire logic global_mode_strap_value,
  input wire logic rx_global_hiz_pin,
  input wire logic rx_differential,
  input wire logic [CH*AMP_W-1:0] rx_amplitude,
  input wire logic [CH-1:0] rx_pulse_valid,
  output logic [CH-1:0] e1_mode,
  output logic [CH*2-1:0] term_kind,
  output logic [CH*2-1:0] internal_term_resistor,
  output logic [CH-1:0] external_term_resistor,
  output logic [CH*2-1:0] monitor_gain_sel,
  output logic [CH-1:0] rx_mark,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================================
  // Channel select, per-channel configuration and peak storage
  logic [3:0] sel_reg;
  logic [CH-1:0] channel_config_reg;
  logic [7:0] rx_config_reg0 [CH];
  logic [7:0] rx_config_reg2 [CH];
  logic [AMP_W-1:0] peak_reg [CH];

  // ==========================================================================
  // AXI4-Lite write side: address and data taken in either order
  logic aw_held_reg;
  logic w_held_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held_reg || aw_take;
  wire w_have = w_held_reg || w_take;
  wire wr_fire = aw_have && w_have && !bvalid_reg;
  wire [AXI_AW-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire wr_byte0 = wr_fire && wr_strb[0];
  wire wr_mapped = wr_addr == CHAN_SEL_OFF || wr_addr == CHAN_CFG_OFF ||
    wr_addr == RX_CFG0_OFF || wr_addr == RX_CFG2_OFF;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= AXI_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (aw_take && !wr_fire)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take && !wr_fire)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Configuration writes, addressed through the channel select
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sel_reg <= 4'h0;
      channel_config_reg <= {CH{CHAN_CFG_RST[E1_BIT]}};
    end
    else if (wr_byte0 && wr_addr == CHAN_SEL_OFF)
    begin
      sel_reg <= wr_data[3:0];
    end
    else if (wr_byte0 && wr_addr == CHAN_CFG_OFF)
    begin
      channel_config_reg[sel_reg] <= wr_data[E1_BIT];
    end
  end

  // ==========================================================================
  // Per-channel decode
  genvar g;
  generate
    for (g = 0; g < CH; g++)
    begin : g_ch
      wire [7:0] cfg0 = rx_config_reg0[g];
      wire [AMP_W-1:0] amp = rx_amplitude[g*AMP_W +: AMP_W];
      wire term_ext = !rx_global_hiz_pin || cfg0[TERM_EXT_BIT];
      wire part_int = cfg0[PART_INT_BIT];
      wire [1:0] kind = term_ext ? RTM_TERM_EXT :
        (part_int ? RTM_TERM_PART : RTM_TERM_FULL);
      wire [1:0] gain_raw = rx_config_reg2[g][GAIN_LSB +: 2];

      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          rx_config_reg0[g] <= RX_CFG0_RST;
          rx_config_reg2[g] <= RX_CFG2_RST;
        end
        else if (wr_byte0 && sel_reg == 4'(g) && wr_addr == RX_CFG0_OFF)
        begin
          rx_config_reg0[g] <= wr_data[7:0];
        end
        else if (wr_byte0 && sel_reg == 4'(g) && wr_addr == RX_CFG2_OFF)
        begin
          rx_config_reg2[g] <= wr_data[7:0];
        end
      end

      // A slow decay lets the threshold follow a falling line level.
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          peak_reg[g] <= '0;
          rx_mark[g] <= 1'b0;
        end
        else if (rx_pulse_valid[g])
        begin
          peak_reg[g] <= (amp > peak_reg[g]) ? amp :
            peak_reg[g] - AMP_W'(peak_reg[g] != '0);
          rx_mark[g] <= amp > (peak_reg[g] >> 1);
        end
      end

      assign e1_mode[g] = global_mode_strap_enable ?
        global_mode_strap_value : channel_config_reg[g];

      assign term_kind[g*2 +: 2] = kind;
      assign external_term_resistor[g] = (kind != RTM_TERM_FULL);
      assign internal_term_resistor[g*2 +: 2] = term_ext ? 2'b00 :
        cfg0[TERM_RES_LSB +: 2];
      assign monitor_gain_sel[g*2 +: 2] = rx_differential ? gain_raw :
        RTM_GAIN_0DB;
    end
  endgenerate

  // ==========================================================================
  // AXI4-Lite read side
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire [7:0] stat_sel = {rx_mark[sel_reg], monitor_gain_sel[sel_reg*2 +: 2],
    internal_term_resistor[sel_reg*2 +: 2], term_kind[sel_reg*2 +: 2],
    e1_mode[sel_reg]};
  wire rd_hit = s_axi_araddr == CHAN_SEL_OFF ||
    s_axi_araddr == CHAN_CFG_OFF || s_axi_araddr == RX_CFG0_OFF ||
    s_axi_araddr == RX_CFG2_OFF || s_axi_araddr == STATUS_OFF ||
    s_axi_araddr == PEAK_OFF;
  wire [7:0] rd_byte =
    s_axi_araddr == CHAN_SEL_OFF ? {4'h0, sel_reg} :
    s_axi_araddr == CHAN_CFG_OFF ? {7'h00, channel_config_reg[sel_reg]} :
    s_axi_araddr == RX_CFG0_OFF ? rx_config_reg0[sel_reg] :
    s_axi_araddr == RX_CFG2_OFF ? rx_config_reg2[sel_reg] :
    s_axi_araddr == STATUS_OFF ? stat_sel :
    s_axi_araddr == PEAK_OFF ? 8'(peak_reg[sel_reg]) : 8'h00;

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= AXI_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- rtm_rx_term_ctrl_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtm_rx_term_ctrl_test
  import rtm_pkg::*;
;
  logic clk, rst, rx_global_hiz_pin, rx_differential;
  logic global_mode_strap_enable, global_mode_strap_value;
  logic [NUM_CH*AMP_W-1:0] rx_amplitude;
  logic [NUM_CH-1:0] rx_pulse_valid, e1_mode, external_term_resistor, rx_mark;
  logic [NUM_CH*2-1:0] term_kind, internal_term_resistor, monitor_gain_sel;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [4:0] ch5;
  // Full internal matching is only used with a transformer fitted.
  logic [7:0] cfg [5] = '{8'h02, 8'h13, 8'h17, 8'h06, 8'h01};
  logic [4:0] tv [5] = '{5'h14, 5'h0f, 5'h01, 5'h01, 5'h12};
  int fail_count = 0, n_checks = 0, cyc = 0;

  assign ch5 = {term_kind[11:10], internal_term_resistor[11:10],
    external_term_resistor[5]};
  rtm_rx_term_ctrl #(.CH(NUM_CH)) uut (.*);

  // =========
  task chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Handshakes are judged 1 ns after the edge, where nothing moves.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    #1;
    while (s_axi_bready)
    begin
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      if (b)
        chk(s_axi_bresp, er);
      @(posedge clk);
      if (aw)
        s_axi_awvalid <= 1'h0;
      if (w)
        s_axi_wvalid <= 1'h0;
      if (b)
        s_axi_bready <= 1'h0;
      #1;
    end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ar, r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    #1;
    while (s_axi_rready)
    begin
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      if (r)
        chk({s_axi_rresp, s_axi_rdata}, {er, d});
      @(posedge clk);
      if (ar)
        s_axi_arvalid <= 1'h0;
      if (r)
        s_axi_rready <= 1'h0;
      #1;
    end
  endtask

  task pulse(input logic [7:0] amp, input logic m);
    rx_amplitude[7:0] <= amp;
    rx_pulse_valid[0] <= 1'h1;
    @(posedge clk);
    #1;
    rx_pulse_valid[0] <= 1'h0;
    chk(rx_mark[0], m);
    #1;
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // =========
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      fail_count++;
      end_of_test;
    end
  end

  initial
  begin
    {rst, global_mode_strap_enable, global_mode_strap_value} = 3'h7;
    {rx_global_hiz_pin, rx_differential, rx_pulse_valid} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {rx_amplitude, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    #1;
    chk(term_kind, 36'h0);
    rx_global_hiz_pin <= 1'h1;
    pulse(8'h64, 1'h1);
    pulse(8'h32, 1'h0);
    pulse(8'h32, 1'h1);
    rd(PEAK_OFF, 32'h62, AXI_OKAY);
    rd(8'h1c, 32'h0, AXI_SLVERR);
    wr(8'h1c, 32'h0, AXI_SLVERR);
    $display("slicer test done");
    chk(e1_mode, 36'hffff);
    global_mode_strap_value <= 1'h0;
    #1;
    chk(e1_mode, 36'h0);
    global_mode_strap_enable <= 1'h0;
    wr(CHAN_SEL_OFF, 32'h3, AXI_OKAY);
    wr(CHAN_CFG_OFF, 32'h0, AXI_OKAY);
    chk(e1_mode, 36'hfff7);
    $display("mode test done");
    wr(CHAN_SEL_OFF, 32'h5, AXI_OKAY);
    for (int i = 0; i < 5; i++)
    begin
      wr(RX_CFG0_OFF, {24'h0, cfg[i]}, AXI_OKAY);
      chk(ch5, tv[i]);
    end
    rd(STATUS_OFF, 32'h0d, AXI_OKAY);
    rd(CHAN_SEL_OFF, 32'h5, AXI_OKAY);
    rx_global_hiz_pin <= 1'h0;
    #1;
    chk(ch5, 36'h1);
    $display("termination test done");
    rx_differential <= 1'h1;
    for (int g = 0; g < 4; g++)
    begin
      wr(RX_CFG2_OFF, 32'(g), AXI_OKAY);
      chk(monitor_gain_sel[11:10], g[1:0]);
    end
    wr(RX_CFG2_OFF, 32'h0, AXI_OKAY);
    chk(monitor_gain_sel, 36'h0);
    wr(RX_CFG2_OFF, 32'h3, AXI_OKAY);
    rx_differential <= 1'h0;
    #1;
    chk(monitor_gain_sel, 36'h0);
    $display("gain test done");
    end_of_test;
  end
endmodule
`default_nettype wire
